// ==== hw/aux_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface aux_if;
  logic tick;
  logic inrush_block;
  logic [breaker_pkg::NUM_AUX-1:0] aux_in;
  breaker_pkg::aux_mode_t mode [breaker_pkg::NUM_AUX];
  logic [breaker_pkg::SET_W-1:0] delay [breaker_pkg::NUM_AUX];
  logic latch_clear;
  logic [breaker_pkg::NUM_AUX-1:0] expired;
  logic [breaker_pkg::NUM_AUX-1:0] trip;
  logic [breaker_pkg::NUM_AUX-1:0] alarm;
  modport ctrl (output tick, inrush_block, aux_in, mode, delay, latch_clear,
    input expired, trip, alarm);
  modport timers (input tick, inrush_block, aux_in, mode, delay, latch_clear,
    output expired, trip, alarm);
endinterface : aux_if
`default_nettype wire

// ==== hw/aux_timers.sv ====
`timescale 1ns/1ps
`default_nettype none
module aux_timers (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronised reset
  aux_if.timers bus // aux timer channel
);
  genvar g;
  generate
    for (g = 0; g < breaker_pkg::NUM_AUX; g++) begin : ch
      logic [breaker_pkg::SET_W-1:0] cnt_ff;
      logic exp_ff;
      logic latch_ff;
      wire enabled = (bus.mode[g] != breaker_pkg::AUX_DISABLED);
      wire run = enabled && bus.aux_in[g];
      wire hit = run && (cnt_ff >= bus.delay[g]);
      wire is_trip = (bus.mode[g] == breaker_pkg::AUX_TRIP)
        || (bus.mode[g] == breaker_pkg::AUX_TRIP_LATCH)
        || (bus.mode[g] == breaker_pkg::AUX_TRIP_INRUSH && !bus.inrush_block);
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          cnt_ff <= '0;
          exp_ff <= 1'b0;
          latch_ff <= 1'b0;
        end else begin
          if (!run) begin
            cnt_ff <= '0;
          end else if (bus.tick && !hit) begin
            cnt_ff <= cnt_ff + 1'b1;
          end
          exp_ff <= hit;
          if (hit && bus.mode[g] == breaker_pkg::AUX_TRIP_LATCH) begin
            latch_ff <= 1'b1;
          end else if (bus.latch_clear || bus.mode[g] != breaker_pkg::AUX_TRIP_LATCH) begin
            latch_ff <= 1'b0;
          end
        end
      end
      assign bus.expired[g] = exp_ff;
      assign bus.trip[g] = (exp_ff && is_trip) || latch_ff;
      assign bus.alarm[g] = exp_ff && (bus.mode[g] == breaker_pkg::AUX_ALARM);
    end
  endgenerate
endmodule : aux_timers
`default_nettype wire

// ==== hw/breaker_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module breaker_control (
  input wire logic clk_sys, // 100 MHz clock
  input wire logic resetn, // async reset, active low
  input wire logic breaker_closed_contact, // aux contact, high when closed
  input wire logic breaker_open_contact, // aux contact, high when open
  input wire logic closed_contact_used, // closed contact assigned
  input wire logic open_contact_used, // open contact assigned
  input wire logic trip_req_local, // key or menu trip pulse
  input wire logic trip_req_input, // binary input trip pulse
  input wire logic trip_req_remote, // remote link trip pulse
  input wire logic close_req_local, // key or menu close pulse
  input wire logic close_req_input, // binary input close pulse
  input wire logic close_req_remote, // remote link close pulse
  input wire logic protection_trip, // protection element trip level
  input wire logic fault_ack, // acknowledge pulse
  input wire logic undervoltage_coil, // 1 selects inverted trip contact
  input wire logic [15:0] trip_pulse_length, // ticks
  input wire logic [15:0] close_pulse_length, // ticks
  input wire logic [15:0] close_delay, // ticks
  input wire logic breaker_healthy_input, // breaker can close
  input wire logic healthy_used, // healthy input assigned
  input wire logic [15:0] breaker_healthy_wait, // ticks
  input wire logic [3:0] aux_inputs, // aux_input_one..four
  input wire logic [2:0] aux_mode_one, // mode of timer one
  input wire logic [2:0] aux_mode_two, // mode of timer two
  input wire logic [2:0] aux_mode_three, // mode of timer three
  input wire logic [2:0] aux_mode_four, // mode of timer four
  input wire logic [15:0] aux_delay_one, // ticks
  input wire logic [15:0] aux_delay_two, // ticks
  input wire logic [15:0] aux_delay_three, // ticks
  input wire logic [15:0] aux_delay_four, // ticks
  input wire logic [2:0] inrush_phase, // per-phase inrush detect
  input wire logic latch_reset_input, // reset binary input
  input wire logic latch_reset_panel, // front panel reset
  input wire logic latch_reset_remote, // remote reset
  input wire logic bridge_input_five, // instant bridge input
  input wire logic bridge_input_six, // instant bridge input
  input wire logic [4:0] log_rd_index, // 0 = newest entry
  output logic trip_output_contact, // trip contact drive
  output logic lockout_output_contact, // 1 = nc contact closed
  output logic close_output, // close coil pulse
  output logic trip_pulse_out, // manual trip pulse
  output logic healthy_alarm, // healthy wait expired
  output logic close_refused, // one-cycle refusal pulse
  output logic trip_refused, // one-cycle refusal pulse
  output logic [3:0] aux_expired, // timer expiry indicators
  output logic [3:0] aux_alarm, // alarm signals
  output logic [3:0] aux_trip, // trip signals
  output logic bridge_out_five, // bridge to led or relay
  output logic bridge_out_six, // bridge to led or relay
  output logic [31:0] log_rd_stamp, // stamp of selected entry
  output logic [2:0] log_rd_origin, // origin of selected entry
  output logic [4:0] log_count // entries held
);
  logic rs1_ff, rst_n;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rs1_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rst_n <= rs1_ff;
    end
  end

  // 10 ms tick and free-running stamp
  logic [breaker_pkg::TICK_W-1:0] div_ff;
  logic tick_ff;
  logic [breaker_pkg::STAMP_W-1:0] stamp_ff;
  wire div_end = (div_ff == breaker_pkg::TICK_W'(breaker_pkg::TICK_CYCLES - 1));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
      stamp_ff <= '0;
    end else begin
      div_ff <= div_end ? '0 : div_ff + 1'b1;
      tick_ff <= div_end;
      if (div_end) stamp_ff <= stamp_ff + 1'b1;
    end
  end

  // breaker state
  wire is_closed = closed_contact_used ? breaker_closed_contact : !breaker_open_contact;
  wire is_open = open_contact_used ? breaker_open_contact : !breaker_closed_contact;
  wire trip_req = trip_req_local | trip_req_input | trip_req_remote;
  wire close_req = close_req_local | close_req_input | close_req_remote;

  // aux timers
  aux_if abus ();
  assign abus.tick = tick_ff;
  assign abus.inrush_block = |inrush_phase;
  assign abus.aux_in = aux_inputs;
  assign abus.mode[0] = breaker_pkg::aux_mode_t'(aux_mode_one);
  assign abus.mode[1] = breaker_pkg::aux_mode_t'(aux_mode_two);
  assign abus.mode[2] = breaker_pkg::aux_mode_t'(aux_mode_three);
  assign abus.mode[3] = breaker_pkg::aux_mode_t'(aux_mode_four);
  assign abus.delay[0] = aux_delay_one;
  assign abus.delay[1] = aux_delay_two;
  assign abus.delay[2] = aux_delay_three;
  assign abus.delay[3] = aux_delay_four;
  assign abus.latch_clear = latch_reset_input | latch_reset_panel | latch_reset_remote;
  aux_timers u_aux (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(abus)
  );

  // fault latch: protection or external trip
  wire ext_trip = |abus.trip;
  logic [3:0] ext_prev_ff;
  wire [3:0] ext_rise = abus.trip & ~ext_prev_ff;
  wire fault_now = protection_trip | ext_trip;
  logic fault_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_ff <= 1'b0;
      ext_prev_ff <= '0;
    end else begin
      ext_prev_ff <= abus.trip;
      if (fault_now) fault_ff <= 1'b1;
      else if (fault_ack) fault_ff <= 1'b0;
    end
  end
  wire locked = fault_ff | fault_now;

  // manual trip pulse
  logic [15:0] tcnt_ff;
  logic tpulse_ff;
  wire trip_ok = trip_req && is_closed;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tpulse_ff <= 1'b0;
      tcnt_ff <= '0;
    end else if (trip_ok) begin
      tpulse_ff <= 1'b1;
      tcnt_ff <= '0;
    end else if (tpulse_ff && tick_ff) begin
      tcnt_ff <= tcnt_ff + 1'b1;
      if (tcnt_ff + 16'h0001 >= trip_pulse_length) tpulse_ff <= 1'b0;
    end
  end

  // close sequence
  breaker_pkg::close_state_t st_ff, nxt_st;
  logic [15:0] ccnt_ff, nxt_ccnt;
  logic nxt_alarm, alarm_ff;
  wire abort = fault_now | trip_ok;
  always_comb begin
    nxt_st = st_ff;
    nxt_ccnt = ccnt_ff;
    nxt_alarm = alarm_ff;
    case (st_ff)
      breaker_pkg::CL_IDLE: begin
        if (close_req && is_open && !locked && !abort) begin
          nxt_st = breaker_pkg::CL_DELAY;
          nxt_ccnt = '0;
        end
      end
      breaker_pkg::CL_DELAY: begin
        if (ccnt_ff >= close_delay) begin
          nxt_st = breaker_pkg::CL_HEALTH;
          nxt_ccnt = '0;
        end else if (tick_ff) begin
          nxt_ccnt = ccnt_ff + 1'b1;
        end
      end
      breaker_pkg::CL_HEALTH: begin
        if (!healthy_used || breaker_healthy_input) begin
          nxt_st = breaker_pkg::CL_PULSE;
          nxt_ccnt = '0;
        end else if (ccnt_ff >= breaker_healthy_wait) begin
          nxt_st = breaker_pkg::CL_LOCK;
          nxt_alarm = 1'b1;
        end else if (tick_ff) begin
          nxt_ccnt = ccnt_ff + 1'b1;
        end
      end
      breaker_pkg::CL_PULSE: begin
        if (tick_ff) nxt_ccnt = ccnt_ff + 1'b1;
        if (tick_ff && ccnt_ff + 16'h0001 >= close_pulse_length) begin
          nxt_st = breaker_pkg::CL_IDLE;
        end
      end
      breaker_pkg::CL_LOCK: begin
        if (fault_ack) begin
          nxt_st = breaker_pkg::CL_IDLE;
          nxt_alarm = 1'b0;
        end
      end
      default: nxt_st = breaker_pkg::CL_IDLE;
    endcase
    if (abort && st_ff != breaker_pkg::CL_LOCK) begin
      nxt_st = breaker_pkg::CL_IDLE;
      // alarm only stands while in lock
      nxt_alarm = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= breaker_pkg::CL_IDLE;
      ccnt_ff <= '0;
      alarm_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      ccnt_ff <= nxt_ccnt;
      alarm_ff <= nxt_alarm;
    end
  end
  wire close_drive = (nxt_st == breaker_pkg::CL_PULSE) && !locked;
  // healthy wait expiry opens the lockout contact too
  wire health_lock = (nxt_st == breaker_pkg::CL_LOCK);
  wire close_bad = close_req && (st_ff == breaker_pkg::CL_IDLE)
    && (!is_open || locked || abort);

  // fault log, newest at wr_ff-1
  logic [breaker_pkg::STAMP_W-1:0] log_stamp [breaker_pkg::LOG_DEPTH];
  logic [2:0] log_org [breaker_pkg::LOG_DEPTH];
  logic [4:0] wr_ff, cnt_ff;
  logic [2:0] org;
  always_comb begin
    org = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (ext_rise[i]) org = 3'(i + 1);
    end
  end
  wire log_we = |ext_rise;
  wire [4:0] wr_nxt = (wr_ff == 5'(breaker_pkg::LOG_DEPTH - 1)) ? 5'h00 : wr_ff + 5'h01;
  wire [5:0] rd_raw = {1'b0, wr_ff} + 6'(breaker_pkg::LOG_DEPTH) - 6'h01 - {1'b0, log_rd_index};
  wire [5:0] rd_wrap = (rd_raw >= 6'(breaker_pkg::LOG_DEPTH)) ?
    rd_raw - 6'(breaker_pkg::LOG_DEPTH) : rd_raw;
  wire [4:0] rd_idx = rd_wrap[4:0];
  always_ff @(posedge clk_sys) begin
    if (log_we) begin
      log_stamp[wr_ff] <= stamp_ff;
      log_org[wr_ff] <= org;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff <= '0;
      cnt_ff <= '0;
    end else if (log_we) begin
      wr_ff <= wr_nxt;
      if (cnt_ff != 5'(breaker_pkg::LOG_DEPTH)) cnt_ff <= cnt_ff + 5'h01;
    end
  end
  wire rd_valid = (log_rd_index < cnt_ff) && (rd_idx < 5'(breaker_pkg::LOG_DEPTH));

  // registered outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trip_output_contact <= 1'b0;
      lockout_output_contact <= 1'b1;
      close_output <= 1'b0;
      trip_pulse_out <= 1'b0;
      healthy_alarm <= 1'b0;
      close_refused <= 1'b0;
      trip_refused <= 1'b0;
      aux_expired <= '0;
      aux_alarm <= '0;
      aux_trip <= '0;
      bridge_out_five <= 1'b0;
      bridge_out_six <= 1'b0;
      log_rd_stamp <= '0;
      log_rd_origin <= '0;
      log_count <= '0;
    end else begin
      trip_output_contact <= undervoltage_coil ? !locked : locked;
      lockout_output_contact <= !(locked || health_lock);
      close_output <= close_drive;
      trip_pulse_out <= tpulse_ff | trip_ok;
      healthy_alarm <= nxt_alarm;
      close_refused <= close_bad;
      trip_refused <= trip_req && !is_closed;
      aux_expired <= abus.expired;
      aux_alarm <= abus.alarm;
      aux_trip <= abus.trip;
      bridge_out_five <= bridge_input_five;
      bridge_out_six <= bridge_input_six;
      log_rd_stamp <= rd_valid ? log_stamp[rd_idx] : '0;
      log_rd_origin <= rd_valid ? log_org[rd_idx] : '0;
      log_count <= cnt_ff;
    end
  end
endmodule : breaker_control
`default_nettype wire

// ==== hw/breaker_pkg.sv ====
package breaker_pkg;
  // time base
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 20;
  // settings in 10 ms ticks
  localparam int SET_W = 16;
  localparam logic [15:0] PULSE_DEFAULT = 16'h000a;    // 0.10 s
  localparam logic [15:0] PULSE_MAX = 16'h03e8;        // 10.00 s
  localparam logic [15:0] CLOSE_DELAY_MAX = 16'h4e20;  // 200.0 s
  localparam logic [15:0] HEALTHY_WAIT_DEFAULT = 16'h0640; // 16 s
  localparam logic [15:0] HEALTHY_WAIT_MAX = 16'h4e20;
  localparam logic [15:0] AUX_DELAY_MAX = 16'hea60;    // 600.00 s
  localparam int NUM_AUX = 4;
  localparam int LOG_DEPTH = 20;
  localparam int LOG_IDX_W = 5;
  localparam int STAMP_W = 32;
  localparam int ORIGIN_W = 3;

  typedef enum logic [2:0] {
    AUX_DISABLED = 3'h0,
    AUX_TRIP = 3'h1,
    AUX_ALARM = 3'h2,
    AUX_TRIP_INRUSH = 3'h3,
    AUX_TRIP_LATCH = 3'h4,
    AUX_LOAD_SHED = 3'h5,
    AUX_AR_LS_HI = 3'h6,
    AUX_AR_LS_LO = 3'h7
  } aux_mode_t;

  // close sequence, gray coded from idle through pulse; health to lock flips two bits
  typedef enum logic [2:0] {
    CL_IDLE = 3'b000,
    CL_DELAY = 3'b001,
    CL_HEALTH = 3'b011,
    CL_PULSE = 3'b010,
    CL_LOCK = 3'b110
  } close_state_t;
endpackage : breaker_pkg

// ==== test/breaker_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module breaker_checker (
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic breaker_closed_contact, // closed
  input wire logic breaker_open_contact, // open
  input wire logic protection_trip, // fault
  input wire logic fault_ack, // ack
  input wire logic undervoltage_coil, // uv mode
  input wire logic [2:0] aux_mode_one, // mode one
  input wire logic [2:0] aux_mode_three, // mode three
  input wire logic [2:0] inrush_phase, // inrush
  input wire logic latch_reset_input, // clear
  input wire logic latch_reset_panel, // clear
  input wire logic latch_reset_remote, // clear
  input wire logic bridge_input_five, // bridge in
  input wire logic bridge_out_five, // bridge out
  input wire logic trip_output_contact, // trip
  input wire logic lockout_output_contact, // lockout
  input wire logic close_output, // close
  input wire logic trip_pulse_out, // trip pulse
  input wire logic [3:0] aux_alarm, // alarms
  input wire logic [3:0] aux_trip // trips
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_trip_when_closed: assert property (
    $rose(trip_pulse_out) |-> $past(breaker_closed_contact))
    else $error("trip pulse while open");
  a_close_when_open: assert property (
    $rose(close_output) |-> $past(breaker_open_contact) && $past(lockout_output_contact))
    else $error("close not allowed");
  a_trip_aborts_close: assert property (
    protection_trip |-> ##[1:2] !close_output)
    else $error("close not aborted");
  a_shunt_trip_latch: assert property (
    protection_trip && !undervoltage_coil |-> ##[1:2] trip_output_contact && !lockout_output_contact)
    else $error("shunt trip missing");
  a_uv_trip_release: assert property (
    protection_trip && undervoltage_coil |-> ##[1:2] !trip_output_contact)
    else $error("uv contact held");
  a_lockout_needs_ack: assert property (
    $rose(lockout_output_contact) |-> $past(fault_ack) || $past(fault_ack, 2))
    else $error("lockout left without ack");
  a_bridge_follows: assert property (
    bridge_out_five == $past(bridge_input_five))
    else $error("bridge mismatch");
  // a latched channel needs two edges to drain after disable
  a_disabled_silent: assert property (
    aux_mode_one == 3'h0 && $past(aux_mode_one) == 3'h0 && $past(aux_mode_one, 2) == 3'h0
      |-> !aux_trip[0] && !aux_alarm[0])
    else $error("disabled timer active");
  // clear edge, latch drop, registered output: two edges back
  a_latch_held: assert property (
    $fell(aux_trip[2]) && aux_mode_three == 3'h4
      |-> $past(latch_reset_input | latch_reset_panel | latch_reset_remote, 2))
    else $error("latched trip dropped");
  a_inrush_blocks: assert property (
    (aux_mode_one == 3'h3 && inrush_phase != 3'h0) [*3] |-> !aux_trip[0])
    else $error("inrush not blocking");
endmodule : breaker_checker
bind breaker_control breaker_checker i_breaker_checker (.*);
`default_nettype wire

// ==== test/breaker_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module breaker_model (
  input wire logic clk_sys, // clock
  input wire logic close_output, // close coil
  input wire logic trip_pulse_out, // trip coil
  input wire logic trip_output_contact, // relay contact
  input wire logic undervoltage_coil, // uv coil wiring
  input wire logic set_closed, // hand close
  input wire logic set_open, // hand open
  input wire logic healthy_en, // energy stored
  output logic breaker_closed_contact, // made when closed
  output logic breaker_open_contact, // made when open
  output logic breaker_healthy_input // can close
);
  logic closed_ff = 1'b0;
  logic nxt_closed;
  wire logic trip_coil = trip_pulse_out | (undervoltage_coil ^ trip_output_contact);
  // trip-free: trip beats close
  assign nxt_closed = (trip_coil | set_open) ? 1'b0 : (close_output | set_closed | closed_ff);
  always @(posedge clk_sys) begin
    closed_ff <= nxt_closed;
  end
  assign breaker_closed_contact = closed_ff;
  assign breaker_open_contact = ~closed_ff;
  assign breaker_healthy_input = healthy_en;
endmodule : breaker_model
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic resetn, closed_contact_used, open_contact_used, protection_trip, fault_ack;
  logic trip_req_local, trip_req_input, trip_req_remote, set_closed, set_open;
  logic close_req_local, close_req_input, close_req_remote, healthy_en;
  logic undervoltage_coil, healthy_used, latch_reset_input, latch_reset_panel;
  logic latch_reset_remote, bridge_input_five, bridge_input_six;
  logic [15:0] trip_pulse_length, close_pulse_length, close_delay, breaker_healthy_wait;
  logic [15:0] aux_delay_one, aux_delay_two, aux_delay_three, aux_delay_four;
  logic [3:0] aux_inputs, aux_expired, aux_alarm, aux_trip;
  logic [2:0] aux_mode_one, aux_mode_two, aux_mode_three, aux_mode_four, inrush_phase;
  logic [2:0] log_rd_origin;
  logic [4:0] log_rd_index, log_count;
  logic [31:0] log_rd_stamp;
  logic breaker_closed_contact, breaker_open_contact, breaker_healthy_input;
  logic trip_output_contact, lockout_output_contact, close_output, trip_pulse_out;
  logic healthy_alarm, close_refused, trip_refused, bridge_out_five, bridge_out_six;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  breaker_control i_breaker_control (.*);
  breaker_model i_breaker_model (.*);

  always #5 clk_sys = ~clk_sys;

  task print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask : pulse

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check(s, 1'b1);
  endtask : wait_hi

  initial begin
    resetn = 1'b0;
    {closed_contact_used, open_contact_used, healthy_used, undervoltage_coil} = 4'hc;
    {protection_trip, fault_ack, set_closed, set_open, healthy_en} = 5'h00;
    {trip_req_local, trip_req_input, trip_req_remote} = 3'h0;
    {close_req_local, close_req_input, close_req_remote} = 3'h0;
    {latch_reset_input, latch_reset_panel, latch_reset_remote} = 3'h0;
    {bridge_input_five, bridge_input_six} = 2'h0;
    trip_pulse_length = 16'h000a;
    close_pulse_length = 16'h000a;
    close_delay = 16'h0000;
    breaker_healthy_wait = 16'h0000;
    {aux_delay_one, aux_delay_two, aux_delay_three, aux_delay_four} = 64'h0;
    {aux_mode_one, aux_mode_two, aux_mode_three, aux_mode_four} = 12'h000;
    aux_inputs = 4'h0;
    inrush_phase = 3'h0;
    log_rd_index = 5'h00;
    idle(5);
    resetn = 1'b1;
    fork
      begin
        idle(5);
        aux_inputs = 4'hf;
        idle(3);
        check({aux_expired, aux_trip, aux_alarm}, 12'h000);
        aux_inputs = 4'h0;
        open_contact_used = 1'b0;
        pulse(trip_req_local);
        check({trip_refused, trip_pulse_out}, 2'b10);
        open_contact_used = 1'b1;
        pulse(close_req_input);
        wait_hi(close_output);
        protection_trip = 1'b1;
        idle(2);
        check({close_output, trip_output_contact, lockout_output_contact}, 3'h2);
        pulse(close_req_remote);
        check(close_refused, 1'b1);
        protection_trip = 1'b0;
        idle(2);
        check(trip_output_contact, 1'b1);
        pulse(fault_ack);
        idle(2);
        check({trip_output_contact, lockout_output_contact}, 2'b01);
        pulse(set_closed);
        idle(2);
        pulse(close_req_local);
        check(close_refused, 1'b1);
        pulse(set_open);
        undervoltage_coil = 1'b1;
        idle(2);
        check(trip_output_contact, 1'b1);
        healthy_used = 1'b1;
        pulse(close_req_local);
        wait_hi(healthy_alarm);
        check({close_output, lockout_output_contact}, 2'b00);
        pulse(fault_ack);
        idle(2);
        check({healthy_alarm, lockout_output_contact}, 2'b01);
        healthy_en = 1'b1;
        pulse(close_req_local);
        wait_hi(close_output);
        protection_trip = 1'b1;
        idle(2);
        check({close_output, trip_output_contact}, 2'b00);
        protection_trip = 1'b0;
        idle(2);
        pulse(fault_ack);
        undervoltage_coil = 1'b0;
        idle(2);
        // one inrush-blocked, two alarm, three latched, four trip
        {aux_mode_one, aux_mode_two, aux_mode_three, aux_mode_four} = 12'h6a1;
        inrush_phase = 3'h2;
        aux_inputs = 4'h8;
        idle(3);
        check({aux_trip, log_count, log_rd_origin}, {4'h8, 5'h01, 3'h4});
        check(lockout_output_contact, 1'b0);
        aux_inputs = 4'hf;
        idle(3);
        check({aux_expired, aux_trip, aux_alarm}, 12'hfc2);
        check({log_count, log_rd_origin}, {5'h02, 3'h3});
        inrush_phase = 3'h0;
        idle(3);
        check({aux_trip[0], log_count, log_rd_origin}, {1'b1, 5'h03, 3'h1});
        // older entries; no tick has elapsed yet, so stamps are zero
        log_rd_index = 5'h02;
        idle(2);
        check(log_rd_origin, 3'h4);
        check(log_rd_stamp, 32'h0);
        log_rd_index = 5'h03;
        idle(2);
        check(log_rd_origin, 3'h0);
        log_rd_index = 5'h00;
        for (int m = 5; m < 8; m++) begin
          aux_mode_two = 3'(m);
          idle(3);
          check({aux_trip[1], aux_alarm[1]}, 2'b00);
        end
        for (int i = 0; i < 3; i++) begin
          aux_inputs = 4'h4;
          idle(3);
          aux_inputs = 4'h0;
          idle(3);
          check(aux_trip, 4'h4);
          {latch_reset_remote, latch_reset_panel, latch_reset_input} = 3'h1 << i;
          idle(1);
          {latch_reset_remote, latch_reset_panel, latch_reset_input} = 3'h0;
          idle(2);
          check(aux_trip, 4'h0);
        end
        check(lockout_output_contact, 1'b0);
        pulse(fault_ack);
        idle(2);
        check(lockout_output_contact, 1'b1);
        bridge_input_five = 1'b1;
        idle(2);
        check({bridge_out_five, bridge_out_six, aux_trip, aux_alarm}, 10'h200);
        bridge_input_five = 1'b0;
        bridge_input_six = 1'b1;
        idle(2);
        check({bridge_out_five, bridge_out_six}, 2'b01);
        pulse(set_closed);
        idle(2);
        pulse(trip_req_input);
        check({trip_pulse_out, trip_refused}, 2'b10);
        idle(20);
        check(trip_pulse_out, 1'b1);
        // breaker now open: remote trip refused, pulse still standing
        pulse(trip_req_remote);
        check({trip_pulse_out, trip_refused}, 2'b11);
      end
      begin
        wait (cycles == 20000);
        fail_count++;
      end
    join_any
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
